// *** core/ctig_top.sv ***
// top of the channel timing interrupt generator
`timescale 1ns/1ps
`default_nettype none
//
// Summary of operation
// - main irq on packet and byte match
// - sub irq on packet, byte, frame match
// - mode bit 6 enables sub irq
// - set-mode field selects shared write target
// - mode bit 3 picks live or latched
// - mode bit 1 enables main irq
// - mode bit 0 gates main timing writes
// - 0x16/0x17 read main bit position
// - byte compared only under block sync
// - irq fires at byte change onset
// - 0x1D/0x1E read main packet number
// - main packet compared only under frame sync
// - every-packet bit ignores packet target
// - sub frame counter wraps at maximum
module ctig_top
    import ctig_pkg::*;
(
    // clock, reset, enable
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,

    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output wire logic [7:0]          reg_rdata,

    // main channel position
    input  wire logic [BITPOS_W-1:0] main_bit_position,
    input  wire logic [PKT_W-1:0]    main_packet_count,
    input  wire logic                main_block_sync,
    input  wire logic                main_frame_sync,
    input  wire logic [ACT_W-1:0]    activity_monitor_bits,

    // subchannel position
    input  wire logic [BITPOS_W-1:0] sub_bit_position,
    input  wire logic                sub_pkt_start,
    input  wire logic                sub_block_sync,

    // interrupts
    output wire logic                main_timing_irq,
    output wire logic                sub_timing_irq
);
    typedef struct packed {
        logic [7:0]          mode;
        logic [BYTE_W-1:0]   main_tgt_byte;
        logic [PKT_W-1:0]    main_tgt_pkt;
        logic                main_all;
        logic [BYTE_W-1:0]   sub_tgt_byte;
        logic [PKT_W-1:0]    sub_tgt_pkt;
        logic [FRAME_W-1:0]  sub_tgt_frame;
        logic                sub_all;
        logic [FRAME_W-1:0]  sub_max_frame;
        logic [BITPOS_W-1:0] sub_pre_pos;
        logic [BITPOS_W-1:0] sub_pos_d;
        logic                sub_sync_d;
        logic [7:0]          rd_data;
    } ctig_top_t;

    localparam ctig_top_t TOP_RESET = '{mode: MODE_RESET, rd_data: RD_IDLE,
                                        default: '0};
    // idle set-mode code, only the checks use it
    localparam logic [1:0] SET_NONE_CHK = 2'h0;

    ctig_top_t          st_reg;
    ctig_top_t          st_next;
    logic [1:0]         set_mode;
    logic               sub_ld_lo;
    logic               sub_ld_hi;
    logic [PKT_W-1:0]   sub_pkt;
    logic [FRAME_W-1:0] sub_frame;
    logic               main_wr_ok;
    logic               ce_q;

    ctig_match_if main_if ();
    ctig_match_if sub_if ();

    // strobe at one address
    function automatic logic acc(input logic stb, input logic [7:0] adr,
                                 input logic [7:0] a);
        return stb && (adr == a);
    endfunction : acc

    assign set_mode   = st_reg.mode[MODE_SET_HI:MODE_SET_LO];
    assign main_wr_ok = st_reg.mode[MODE_MAIN_WR];

    // host loads of the sub counters; sub has no frame sync of its own
    assign sub_ld_lo = acc(reg_wr, reg_addr, ADDR_SUB_PKT_LO) &&
                       (set_mode == SET_INIT);
    assign sub_ld_hi = acc(reg_wr, reg_addr, ADDR_SUB_FRAME) &&
                       (set_mode == SET_INIT);

    // main comparator feed
    assign main_if.en        = st_reg.mode[MODE_MAIN_EN];
    assign main_if.blk_sync  = main_block_sync;
    assign main_if.frm_sync  = main_frame_sync;
    assign main_if.all_pkts  = st_reg.main_all;
    assign main_if.pos_byte  = main_bit_position[BITPOS_W-1:BYTE_LSB];
    assign main_if.tgt_byte  = st_reg.main_tgt_byte;
    assign main_if.pos_pkt   = main_packet_count;
    assign main_if.tgt_pkt   = st_reg.main_tgt_pkt;
    assign main_if.pos_frame = '0;
    assign main_if.tgt_frame = '0;

    // sub comparator feed; packet always trusted, frame sync tied high from reset
    assign sub_if.en        = st_reg.mode[MODE_SUB_EN];
    assign sub_if.blk_sync  = sub_block_sync;
    assign sub_if.frm_sync  = 1'b1;
    assign sub_if.all_pkts  = st_reg.sub_all;
    assign sub_if.pos_byte  = sub_bit_position[BITPOS_W-1:BYTE_LSB];
    assign sub_if.tgt_byte  = st_reg.sub_tgt_byte;
    assign sub_if.pos_pkt   = sub_pkt;
    assign sub_if.tgt_pkt   = st_reg.sub_tgt_pkt;
    assign sub_if.pos_frame = sub_frame;
    assign sub_if.tgt_frame = st_reg.sub_tgt_frame;

    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            st_next.rd_data    = RD_IDLE;
            st_next.sub_pos_d  = sub_bit_position;
            st_next.sub_sync_d = sub_block_sync;

            // keep the position seen just before sub block sync
            if (sub_block_sync && !st_reg.sub_sync_d) begin
                st_next.sub_pre_pos = st_reg.sub_pos_d;
            end

            if (reg_wr) begin
                if (reg_addr == ADDR_MODE) begin
                    st_next.mode = reg_wdata & MODE_MASK;
                end

                // main targets move only while the write gate is open
                if (main_wr_ok) begin
                    if (reg_addr == ADDR_MAIN_BYTE_LO) begin
                        st_next.main_tgt_byte[BYTE_W-2:0] = reg_wdata[7:BYTE_LSB];
                    end
                    if (reg_addr == ADDR_MAIN_BYTE_HI) begin
                        st_next.main_tgt_byte[BYTE_W-1] = reg_wdata[HI_BIT];
                    end
                    if (reg_addr == ADDR_MAIN_PKT_LO) begin
                        st_next.main_tgt_pkt[7:0] = reg_wdata;
                    end
                    if (reg_addr == ADDR_MAIN_PKT_HI) begin
                        st_next.main_tgt_pkt[PKT_W-1] = reg_wdata[HI_BIT];
                        st_next.main_all = reg_wdata[EVERY_PKT_BIT];
                    end
                end

                // sub interrupt timing
                if (set_mode == SET_IRQ) begin
                    if (reg_addr == ADDR_SUB_BYTE_LO) begin
                        st_next.sub_tgt_byte[BYTE_W-2:0] = reg_wdata[7:BYTE_LSB];
                    end
                    if (reg_addr == ADDR_SUB_BYTE_HI) begin
                        st_next.sub_tgt_byte[BYTE_W-1] = reg_wdata[HI_BIT];
                    end
                    if (reg_addr == ADDR_SUB_PKT_LO) begin
                        st_next.sub_tgt_pkt[7:0] = reg_wdata;
                    end
                    if (reg_addr == ADDR_SUB_FRAME) begin
                        st_next.sub_tgt_pkt[PKT_W-1] = reg_wdata[HI_BIT];
                        st_next.sub_tgt_frame = reg_wdata[FRAME_LSB +: FRAME_W];
                        st_next.sub_all = reg_wdata[SUB_ALL_BIT];
                    end
                end

                // sub frame maximum
                if (set_mode == SET_MAX && reg_addr == ADDR_SUB_FRAME) begin
                    st_next.sub_max_frame = reg_wdata[FRAME_LSB +: FRAME_W];
                end
            end

            // read data stands only in the cycle after the strobe
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_SUB_BYTE_LO: begin
                        st_next.rd_data = st_reg.mode[MODE_LIVE] ?
                            sub_bit_position[7:0] : st_reg.sub_pre_pos[7:0];
                    end
                    ADDR_SUB_BYTE_HI: begin
                        st_next.rd_data = {7'h00, st_reg.mode[MODE_LIVE] ?
                            sub_bit_position[BITPOS_W-1] :
                            st_reg.sub_pre_pos[BITPOS_W-1]};
                    end
                    ADDR_SUB_PKT_LO: begin
                        st_next.rd_data = sub_pkt[7:0];
                    end
                    ADDR_SUB_FRAME: begin
                        st_next.rd_data = {3'h0, sub_frame, sub_pkt[PKT_W-1]};
                    end
                    ADDR_MAIN_BYTE_LO: begin
                        st_next.rd_data = main_bit_position[7:0];
                    end
                    ADDR_MAIN_BYTE_HI: begin
                        st_next.rd_data = {7'h00, main_bit_position[BITPOS_W-1]};
                    end
                    ADDR_MAIN_PKT_LO: begin
                        st_next.rd_data = main_packet_count[7:0];
                    end
                    ADDR_MAIN_PKT_HI: begin
                        st_next.rd_data = {activity_monitor_bits, 3'h0,
                                           main_packet_count[PKT_W-1]};
                    end
                    // the mode register is write-only and reads as zero
                    default: begin
                        st_next.rd_data = RD_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) st_reg <= TOP_RESET;
        else st_reg <= st_next;
    end

    assign reg_rdata = st_reg.rd_data;

    ctig_match u_main_match (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .m       (main_if.cmp)
    );

    ctig_match u_sub_match (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .m       (sub_if.cmp)
    );

    ctig_sub_counter u_sub_cnt (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .pkt_start   (sub_pkt_start),
        .ld_lo       (sub_ld_lo),
        .ld_hi       (sub_ld_hi),
        .ld_data     (reg_wdata),
        .max_frame   (st_reg.sub_max_frame),
        .pkt_count   (sub_pkt),
        .frame_count (sub_frame)
    );

    assign main_timing_irq = main_if.hit;
    assign sub_timing_irq  = sub_if.hit;

    // helper for the checks below: was the last cycle enabled
    always_ff @(posedge sys_clk) begin
        ce_q <= reset_n ? clk_en : 1'b0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n || !ce_q);

    a_main_wr_gate:  assert property (acc(reg_wr, reg_addr, ADDR_MAIN_BYTE_LO) && !main_wr_ok
        |=> $stable(st_reg.main_tgt_byte))
        else $error("main byte target moved while gated");
    a_main_pkt_wr:   assert property (acc(reg_wr, reg_addr, ADDR_MAIN_PKT_LO) && main_wr_ok
        |=> st_reg.main_tgt_pkt[7:0] == $past(reg_wdata))
        else $error("main packet target not written");
    a_every_pkt_wr:  assert property (acc(reg_wr, reg_addr, ADDR_MAIN_PKT_HI) && main_wr_ok
        |=> st_reg.main_all == $past(reg_wdata[EVERY_PKT_BIT]))
        else $error("every-packet bit not written");
    a_live_read:     assert property (acc(reg_rd, reg_addr, ADDR_SUB_BYTE_LO) &&
        st_reg.mode[MODE_LIVE] |=> reg_rdata == $past(sub_bit_position[7:0]))
        else $error("live sub position read wrong");
    a_latched_read:  assert property (acc(reg_rd, reg_addr, ADDR_SUB_BYTE_LO) &&
        !st_reg.mode[MODE_LIVE] |=> reg_rdata == $past(st_reg.sub_pre_pos[7:0]))
        else $error("latched sub position read wrong");
    a_main_pos_read: assert property (acc(reg_rd, reg_addr, ADDR_MAIN_BYTE_LO)
        |=> reg_rdata == $past(main_bit_position[7:0]))
        else $error("main bit position read wrong");
    a_main_pkt_read: assert property (acc(reg_rd, reg_addr, ADDR_MAIN_PKT_LO)
        |=> reg_rdata == $past(main_packet_count[7:0]))
        else $error("main packet read wrong");
    a_max_select:    assert property (acc(reg_wr, reg_addr, ADDR_SUB_FRAME) &&
        set_mode == SET_MAX |=> st_reg.sub_max_frame == $past(reg_wdata[4:1]))
        else $error("max frame not selected");
    a_sub_init_only: assert property (acc(reg_wr, reg_addr, ADDR_SUB_PKT_LO) &&
        set_mode == SET_NONE_CHK |=> $stable(st_reg.sub_tgt_pkt))
        else $error("sub target moved in idle set mode");
    a_frame_wrap:    assert property (sub_pkt_start && !sub_ld_lo && !sub_ld_hi &&
        sub_pkt == SUB_PKT_LAST && sub_frame == st_reg.sub_max_frame
        |=> sub_frame == 4'h0)
        else $error("frame counter did not wrap");
    a_rd_one_cycle:  assert property (!reg_rd |=> reg_rdata == RD_IDLE)
        else $error("read data held too long");

    c_main_irq:   cover property (main_timing_irq);
    c_sub_irq:    cover property (sub_timing_irq);
    c_every_irq:  cover property (main_timing_irq && st_reg.main_all);
    c_frame_wrap: cover property (sub_pkt_start && sub_pkt == SUB_PKT_LAST &&
                                  sub_frame == st_reg.sub_max_frame);

endmodule : ctig_top
`default_nettype wire

// *** core/ctig_pkg.sv ***
// constants and field layout of the channel timing interrupt generator
package ctig_pkg;
    // register offsets
    localparam logic [7:0] ADDR_MODE         = 8'h05;
    localparam logic [7:0] ADDR_SUB_BYTE_LO  = 8'h06;
    localparam logic [7:0] ADDR_SUB_BYTE_HI  = 8'h07;
    localparam logic [7:0] ADDR_SUB_PKT_LO   = 8'h08;
    localparam logic [7:0] ADDR_SUB_FRAME    = 8'h09;
    localparam logic [7:0] ADDR_MAIN_BYTE_LO = 8'h16;
    localparam logic [7:0] ADDR_MAIN_BYTE_HI = 8'h17;
    localparam logic [7:0] ADDR_MAIN_PKT_LO  = 8'h1D;
    localparam logic [7:0] ADDR_MAIN_PKT_HI  = 8'h1E;
    // mode register fields
    localparam int         MODE_SUB_EN   = 6;
    localparam int         MODE_SET_HI   = 5;
    localparam int         MODE_SET_LO   = 4;
    localparam int         MODE_LIVE     = 3;
    localparam int         MODE_MAIN_EN  = 1;
    localparam int         MODE_MAIN_WR  = 0;
    localparam logic [7:0] MODE_MASK     = 8'h7B;
    localparam logic [7:0] MODE_RESET    = 8'h00;
    // sub set-mode codes
    localparam logic [1:0] SET_MAX  = 2'h3;
    localparam logic [1:0] SET_IRQ  = 2'h2;
    localparam logic [1:0] SET_INIT = 2'h1;
    // field positions
    localparam int BYTE_LSB      = 3;
    localparam int HI_BIT        = 0;
    localparam int EVERY_PKT_BIT = 1;
    localparam int FRAME_LSB     = 1;
    localparam int SUB_ALL_BIT   = 5;
    // widths
    localparam int BITPOS_W = 9;
    localparam int BYTE_W   = 6;
    localparam int PKT_W    = 9;
    localparam int FRAME_W  = 4;
    localparam int ACT_W    = 4;
    // counter limits and idle values
    localparam logic [8:0] SUB_PKT_LAST = 9'h10F;
    localparam logic [7:0] RD_IDLE      = 8'h00;
endpackage : ctig_pkg

// *** core/ctig_match_if.sv ***
// position and target bundle between the top and a comparator
`timescale 1ns/1ps
`default_nettype none
interface ctig_match_if;
    import ctig_pkg::*;
    logic               en;
    logic               blk_sync;
    logic               frm_sync;
    logic               all_pkts;
    logic [BYTE_W-1:0]  pos_byte;
    logic [BYTE_W-1:0]  tgt_byte;
    logic [PKT_W-1:0]   pos_pkt;
    logic [PKT_W-1:0]   tgt_pkt;
    logic [FRAME_W-1:0] pos_frame;
    logic [FRAME_W-1:0] tgt_frame;
    logic               hit;
    modport src (output en, blk_sync, frm_sync, all_pkts, pos_byte, tgt_byte,
                 pos_pkt, tgt_pkt, pos_frame, tgt_frame, input hit);
    modport cmp (input en, blk_sync, frm_sync, all_pkts, pos_byte, tgt_byte,
                 pos_pkt, tgt_pkt, pos_frame, tgt_frame, output hit);
endinterface : ctig_match_if
`default_nettype wire

// *** core/ctig_sub_counter.sv ***
// subchannel packet and frame counters
`timescale 1ns/1ps
`default_nettype none
module ctig_sub_counter
    import ctig_pkg::*;
(
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               clk_en,
    // events and host loads
    input  wire logic               pkt_start,
    input  wire logic               ld_lo,
    input  wire logic               ld_hi,
    input  wire logic [7:0]         ld_data,
    input  wire logic [FRAME_W-1:0] max_frame,
    // counts
    output wire logic [PKT_W-1:0]   pkt_count,
    output wire logic [FRAME_W-1:0] frame_count
);
    typedef struct packed {
        logic [PKT_W-1:0]   pkt;
        logic [FRAME_W-1:0] frame;
    } ctig_cnt_t;

    ctig_cnt_t st_reg;
    ctig_cnt_t st_next;

    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            // a host load beats the packet advance in the same cycle
            if (ld_lo || ld_hi) begin
                if (ld_lo) st_next.pkt[7:0] = ld_data;
                if (ld_hi) begin
                    st_next.pkt[PKT_W-1] = ld_data[HI_BIT];
                    st_next.frame = ld_data[FRAME_LSB +: FRAME_W];
                end
            end else if (pkt_start) begin
                if (st_reg.pkt == SUB_PKT_LAST) begin
                    st_next.pkt = '0;
                    st_next.frame = (st_reg.frame == max_frame) ? '0 :
                                    st_reg.frame + 4'h1;
                end else begin
                    st_next.pkt = st_reg.pkt + 9'h001;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) st_reg <= '0;
        else st_reg <= st_next;
    end

    assign pkt_count   = st_reg.pkt;
    assign frame_count = st_reg.frame;
endmodule : ctig_sub_counter
`default_nettype wire

// *** core/ctig_match.sv ***
// position comparator producing one pulse per match
`timescale 1ns/1ps
`default_nettype none
module ctig_match
    import ctig_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   reset_n,
    input  wire logic   clk_en,
    // positions and targets
    ctig_match_if.cmp   m
);
    typedef struct packed {
        logic [BYTE_W-1:0] byte_prev;
        logic              hit;
    } ctig_match_t;

    ctig_match_t st_reg;
    ctig_match_t st_next;
    logic        cond;
    logic        ce_q;
    logic        ce_qq;

    // packet compared only under frame sync, byte only under block sync
    assign cond = m.en && m.blk_sync && (m.pos_byte == m.tgt_byte) &&
                  (m.pos_frame == m.tgt_frame) &&
                  (m.all_pkts || (m.frm_sync && m.pos_pkt == m.tgt_pkt));

    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            st_next.byte_prev = m.pos_byte;
            // firing only on a byte change keeps one pulse per match
            st_next.hit = cond && (m.pos_byte != st_reg.byte_prev);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) st_reg <= '0;
        else st_reg <= st_next;
    end

    assign m.hit = st_reg.hit;

    always_ff @(posedge sys_clk) begin
        ce_q  <= reset_n ? clk_en : 1'b0;
        ce_qq <= reset_n ? ce_q : 1'b0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n || !ce_q || !ce_qq);

    a_hit_needs_en:  assert property (m.hit |-> $past(m.en))
        else $error("irq without enable");
    a_hit_byte_eq:   assert property (m.hit |-> $past(m.pos_byte) == $past(m.tgt_byte))
        else $error("irq on wrong byte");
    a_hit_onset:     assert property (m.hit |-> $past(m.pos_byte) != $past(m.pos_byte, 2))
        else $error("irq not at byte onset");
    a_hit_single:    assert property (m.hit |=> !m.hit)
        else $error("irq longer than one cycle");
    a_hit_blk_sync:  assert property (m.hit |-> $past(m.blk_sync))
        else $error("irq without block sync");
    a_hit_pkt_eq:    assert property (m.hit && !$past(m.all_pkts) |->
        $past(m.frm_sync) && $past(m.pos_pkt) == $past(m.tgt_pkt))
        else $error("irq on wrong packet");
    a_hit_frame_eq:  assert property (m.hit |-> $past(m.pos_frame) == $past(m.tgt_frame))
        else $error("irq on wrong frame");
endmodule : ctig_match
`default_nettype wire

// *** verification/tb.sv ***
// self-checking testbench of the channel timing interrupt generator
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ctig_pkg::*;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    wire  [7:0] reg_rdata;
    logic [8:0] main_bit_position = 9'h000;
    logic [8:0] main_packet_count = 9'h000;
    logic       main_block_sync = 1'b0;
    logic       main_frame_sync = 1'b0;
    logic [3:0] activity_monitor_bits = 4'h0;
    logic [8:0] sub_bit_position = 9'h000;
    logic       sub_pkt_start = 1'b0;
    logic       sub_block_sync = 1'b0;
    wire        main_timing_irq;
    wire        sub_timing_irq;
    logic [7:0] q_rd[$];
    logic [7:0] q_main[$];
    logic [7:0] q_sub[$];
    logic       rd_pend = 1'b0;
    logic [5:0] b;
    logic [5:0] bs;
    logic [8:0] p;
    int         seed = 4130;
    int         num_errors = 0;
    int         samples_checked = 0;
    ctig_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .main_bit_position(main_bit_position),
        .main_packet_count(main_packet_count), .main_block_sync(main_block_sync),
        .main_frame_sync(main_frame_sync), .activity_monitor_bits(activity_monitor_bits),
        .sub_bit_position(sub_bit_position), .sub_pkt_start(sub_pkt_start),
        .sub_block_sync(sub_block_sync), .main_timing_irq(main_timing_irq),
        .sub_timing_irq(sub_timing_irq));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        tick(1);
        reg_wr    <= 1'b0;
        tick(1);
    endtask : wr
    // expectation is queued before the strobe, popped by the watcher
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        tick(1);
        reg_rd   <= 1'b0;
        tick(1);
    endtask : rd
    // packet written with the irq off, byte with it on; we opens the write gate
    task automatic settgt(input logic [5:0] tb_b, input logic [8:0] tp, input logic all,
                          input logic we);
        wr(ADDR_MODE, {7'h00, we});
        wr(ADDR_MAIN_PKT_LO, tp[7:0]);
        wr(ADDR_MAIN_PKT_HI, {6'h00, all, tp[8]});
        wr(ADDR_MODE, {6'h00, 1'b1, we});
        wr(ADDR_MAIN_BYTE_LO, {tb_b[4:0], 3'h0});
        wr(ADDR_MAIN_BYTE_HI, {7'h00, tb_b[5]});
    endtask : settgt
    // low bits random so a byte repeat still moves the bit position
    task automatic mpos(input logic [8:0] tp, input logic [5:0] tb_b);
        main_packet_count <= tp;
        main_bit_position <= {tb_b, 3'($random(seed))};
        tick(3);
    endtask : mpos
    task automatic pulse;
        sub_pkt_start <= 1'b1;
        tick(1);
        sub_pkt_start <= 1'b0;
        tick(1);
    endtask : pulse
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic final_report;
        num_errors += q_rd.size() + q_main.size() + q_sub.size();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // an irq with no note queued is compared against zero
    always @(posedge sys_clk) begin
        if (rd_pend)
            chk("reg_rdata", q_rd.pop_front(), reg_rdata);
        if (main_timing_irq !== 1'b0)
            chk("main_timing_irq", q_main.size() ? q_main.pop_front() : 8'h00, {7'h0, main_timing_irq});
        if (sub_timing_irq !== 1'b0)
            chk("sub_timing_irq", q_sub.size() ? q_sub.pop_front() : 8'h00, {7'h0, sub_timing_irq});
        rd_pend <= reg_rd;
    end
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
    initial begin
        tick(16);
        reset_n <= 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++) begin
            main_bit_position     <= 9'($random(seed));
            main_packet_count     <= 9'($random(seed));
            activity_monitor_bits <= 4'($random(seed));
            tick(1);
            rd(ADDR_MAIN_BYTE_LO, main_bit_position[7:0]);
            rd(ADDR_MAIN_BYTE_HI, {7'h00, main_bit_position[8]});
            rd(ADDR_MAIN_PKT_LO, main_packet_count[7:0]);
            rd(ADDR_MAIN_PKT_HI, {activity_monitor_bits, 3'h0, main_packet_count[8]});
            rd(ADDR_MODE, 8'h00);
            rd(8'h40 + 8'(i), 8'h00);
        end
        b = 6'({$random(seed)} % 36);
        p = 9'({$random(seed)} % 272);
        mpos(p, b ^ 6'h01);
        main_block_sync <= 1'b1;
        main_frame_sync <= 1'b1;
        settgt(b, p, 1'b0, 1'b1);
        // pass, wrong packet, no frame sync, no block sync, disabled, locked writes
        for (int k = 0; k < 6; k++) begin
            main_frame_sync <= (k != 2);
            main_block_sync <= (k != 3);
            if (k == 4)
                wr(ADDR_MODE, 8'h01);
            if (k == 5) begin
                settgt(b ^ 6'h02, p ^ 9'h001, 1'b0, 1'b0);
            end
            mpos(p ^ 9'(k == 1), b ^ 6'h01);
            if (k == 0 || k == 5)
                q_main.push_back(8'h01);
            mpos(p ^ 9'(k == 1), b);
            mpos(p ^ 9'(k == 1), b);
        end
        settgt(b, p, 1'b1, 1'b1);
        main_frame_sync <= 1'b0;
        mpos(p + 9'h003, b ^ 6'h01);
        // byte changes while frozen; the irq must wait for the first enabled edge
        clk_en <= 1'b0;
        mpos(p + 9'h003, b);
        clk_en <= 1'b1;
        q_main.push_back(8'h01);
        tick(3);
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_SUB_PKT_LO, 8'h05);
        wr(ADDR_SUB_FRAME, 8'h04);
        rd(ADDR_SUB_PKT_LO, 8'h05);
        rd(ADDR_SUB_FRAME, 8'h04);
        wr(ADDR_MODE, 8'h30);
        wr(ADDR_SUB_FRAME, 8'h02);
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_SUB_PKT_LO, 8'h0F);
        wr(ADDR_SUB_FRAME, 8'h03);
        pulse();
        rd(ADDR_SUB_FRAME, 8'h00);
        rd(ADDR_SUB_PKT_LO, 8'h00);
        bs = 6'({$random(seed)} % 36);
        wr(ADDR_MODE, 8'h20);
        wr(ADDR_SUB_BYTE_LO, {bs[4:0], 3'h0});
        wr(ADDR_SUB_BYTE_HI, {7'h00, bs[5]});
        wr(ADDR_SUB_PKT_LO, 8'h02);
        wr(ADDR_SUB_FRAME, 8'h00);
        pulse();
        pulse();
        sub_block_sync <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                wr(ADDR_MODE, 8'h20);
                wr(ADDR_SUB_PKT_LO, 8'h07);
                wr(ADDR_SUB_FRAME, 8'h20);
            end
            wr(ADDR_MODE, k ? 8'h60 : 8'h20);
            sub_bit_position <= {bs ^ 6'h01, 3'h0};
            tick(2);
            if (k)
                q_sub.push_back(8'h01);
            sub_bit_position <= {bs, 3'h5};
            tick(3);
        end
        wr(ADDR_MODE, 8'h08);
        wr(ADDR_SUB_PKT_LO, 8'h33);
        rd(ADDR_SUB_PKT_LO, 8'h02);
        rd(ADDR_SUB_BYTE_LO, {bs[4:0], 3'h5});
        sub_block_sync   <= 1'b0;
        sub_bit_position <= 9'h1A5;
        tick(1);
        sub_block_sync   <= 1'b1;
        sub_bit_position <= 9'h04C;
        tick(2);
        wr(ADDR_MODE, 8'h00);
        rd(ADDR_SUB_BYTE_LO, 8'hA5);
        rd(ADDR_SUB_BYTE_HI, 8'h01);
        tick(4);
        final_report();
    end
endmodule : tb
`default_nettype wire
